// *** core/sstp_pkg.sv ***
package sstp_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFF_TX_BUFFER  = 5'h00;
    localparam logic [4:0] OFF_CLK_SELECT = 5'h04;
    localparam logic [4:0] OFF_CONTROL    = 5'h08;
    localparam logic [4:0] OFF_STATUS     = 5'h0c;
    localparam logic [4:0] OFF_INT_FLAGS  = 5'h10;
    localparam logic [4:0] OFF_INT_MASK   = 5'h14;

    localparam int unsigned DATA_W  = 8;
    localparam int unsigned SEL_W   = 4;
    localparam int unsigned Q_DEPTH = 4;
    localparam int unsigned PTR_W   = 2;
    localparam int unsigned CNT_W   = 3;
    localparam int unsigned BIT_W   = 3;
    localparam int unsigned SYNC_N  = 3;

    localparam logic [DATA_W-1:0] TXB_RESET    = 8'h00;
    localparam logic [SEL_W-1:0]  CLKSEL_RESET = 4'h0;
    localparam logic [CNT_W-1:0]  Q_FULL_CNT   = 3'h4;
    localparam logic [BIT_W-1:0]  LAST_BIT     = 3'h7;
    localparam logic [31:0]       RD_ZERO      = 32'h0000_0000;

    // status bit positions
    localparam int unsigned ST_EMPTY  = 0;
    localparam int unsigned ST_FULL   = 1;
    localparam int unsigned ST_WR_ERR = 2;
    localparam int unsigned ST_CNT_LO = 4;

    typedef enum logic [3:0] {
        SSTP_SRC_SYS_OSC     = 4'h0,
        SSTP_SRC_HF_OSC      = 4'h1,
        SSTP_SRC_MF_OSC      = 4'h2,
        SSTP_SRC_REF_CLK     = 4'h3,
        SSTP_SRC_TMR0_OVF    = 4'h4,
        SSTP_SRC_TMR2_POST   = 4'h5,
        SSTP_SRC_TMR4_POST   = 4'h6,
        SSTP_SRC_TMR6_POST   = 4'h7,
        SSTP_SRC_SIG_TMR_MAT = 4'h8
    } sstp_clk_src_t;

    // bit 0 txr, bit 1 tris, bit 2 latch
    typedef struct packed {
        logic pin_output_latch;
        logic pin_tristate_control;
        logic transmit_data_required;
    } sstp_ctrl_t;
    localparam sstp_ctrl_t CTRL_RESET = 3'h0;

    // bit 0 underflow, bit 1 write error
    typedef struct packed {
        logic tx_write_error_flag;
        logic tx_underflow_flag;
    } sstp_flags_t;
    localparam sstp_flags_t FLAGS_RESET = 2'h0;

    typedef enum logic [1:0] {
        SSTP_LINK_IDLE   = 2'b00,
        SSTP_LINK_ACTIVE = 2'b01
    } sstp_link_t;
endpackage

// *** core/sstp_queue_mem.sv ***
`timescale 1ns/1ps
module sstp_queue_mem
    import sstp_pkg::*;
(
    // clock
    input  wire logic                           clk,
    // write side
    input  wire logic                           wr_en,
    input  wire logic [sstp_pkg::PTR_W-1:0]     wr_addr,
    input  wire logic [sstp_pkg::DATA_W-1:0]    wr_data,
    // read side
    input  wire logic [sstp_pkg::PTR_W-1:0]     rd_addr,
    output logic      [sstp_pkg::DATA_W-1:0]    rd_data
);
    logic [DATA_W-1:0] mem [Q_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// *** core/sstp_slave_tx.sv ***
`timescale 1ns/1ps
module sstp_slave_tx
    import sstp_pkg::*;
(
    // clock and reset
    input  wire logic                           CLOCK,
    input  wire logic                           RST_N,
    // avalon-mm slave
    input  wire logic [4:0]                     AVS_ADDRESS,
    input  wire logic                           AVS_READ,
    input  wire logic                           AVS_WRITE,
    input  wire logic [31:0]                    AVS_WRITEDATA,
    output logic      [31:0]                    AVS_READDATA,
    output logic                                AVS_WAITREQUEST,
    // serial link
    input  wire logic                           SCK,
    input  wire logic                           SS_N,
    input  wire logic                           SDI,
    output logic                                SDO_O,
    output logic                                SDO_OE,
    // system
    output logic [sstp_pkg::SEL_W-1:0]          CLK_SEL,
    output logic                                IRQ
);
    import sstp_pkg::*;

    // synchronisers: first stage read only by the second
    logic [SYNC_N-1:0] sck_sync_reg, ss_sync_reg, sdi_sync_reg;
    logic              sck_f_reg, sel_f_reg;
    wire               sck_stable = sck_sync_reg[1] == sck_sync_reg[2];
    wire               ss_stable  = ss_sync_reg[1] == ss_sync_reg[2];
    wire               sck_rise   = sck_stable && sck_sync_reg[2] && !sck_f_reg;
    wire               sck_fall   = sck_stable && !sck_sync_reg[2] && sck_f_reg;
    wire               sel_now    = ss_stable ? !ss_sync_reg[2] : sel_f_reg;
    wire               sel_start  = sel_now && !sel_f_reg;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sck_sync_reg <= '0;
            ss_sync_reg  <= '1;
            sdi_sync_reg <= '0;
            sck_f_reg    <= 1'b0;
            sel_f_reg    <= 1'b0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], SCK};
            ss_sync_reg  <= {ss_sync_reg[1:0], SS_N};
            sdi_sync_reg <= {sdi_sync_reg[1:0], SDI};
            if (sck_stable) sck_f_reg <= sck_sync_reg[2];
            sel_f_reg    <= sel_now;
        end
    end

    // registers
    sstp_ctrl_t          ctrl_reg;
    sstp_flags_t         flags_reg, mask_reg, flags_next;
    logic [SEL_W-1:0]    clksel_reg;
    logic                wr_err_st_reg;
    logic                ack_reg;
    logic [31:0]         rdata_reg;

    // avalon decode
    wire acc       = AVS_READ || AVS_WRITE;
    wire wr_ok     = AVS_WRITE && ack_reg;
    wire rd_ok     = AVS_READ && ack_reg;
    wire hit_txb   = AVS_ADDRESS == OFF_TX_BUFFER;
    wire hit_clk   = AVS_ADDRESS == OFF_CLK_SELECT;
    wire hit_ctrl  = AVS_ADDRESS == OFF_CONTROL;
    wire hit_stat  = AVS_ADDRESS == OFF_STATUS;
    wire hit_flags = AVS_ADDRESS == OFF_INT_FLAGS;
    wire hit_mask  = AVS_ADDRESS == OFF_INT_MASK;

    // one wait state so read data always comes from a register
    assign AVS_WAITREQUEST = acc && !ack_reg;
    assign AVS_READDATA    = rdata_reg;

    // transmit queue
    logic [PTR_W:0]      wr_ptr_reg, rd_ptr_reg;
    logic [CNT_W-1:0]    count_reg;
    logic [DATA_W-1:0]   head_data;
    wire                 q_empty  = count_reg == '0;
    wire                 q_full   = count_reg == Q_FULL_CNT;
    wire                 txb_wr   = wr_ok && hit_txb;
    wire                 push     = txb_wr && !q_full;
    wire                 push_err = txb_wr && q_full;

    sstp_queue_mem u_mem (
        .clk     (CLOCK),
        .wr_en   (push),
        .wr_addr (wr_ptr_reg[PTR_W-1:0]),
        .wr_data (AVS_WRITEDATA[DATA_W-1:0]),
        .rd_addr (rd_ptr_reg[PTR_W-1:0]),
        .rd_data (head_data)
    );

    // link state and shifting
    sstp_link_t          link_reg, link_next;
    logic [BIT_W-1:0]    bit_cnt_reg;
    logic [DATA_W-1:0]   tx_byte_reg, rx_shift_reg, last_rx_reg;
    wire                 byte_end = link_reg == SSTP_LINK_ACTIVE && sck_fall
                                    && bit_cnt_reg == LAST_BIT;
    wire                 load     = sel_start || (byte_end && sel_now);
    wire [DATA_W-1:0]    recv_byte = byte_end ? rx_shift_reg : last_rx_reg;
    wire                 pop      = load && ctrl_reg.transmit_data_required
                                    && !q_empty;
    wire                 underflow_ev = load && ctrl_reg.transmit_data_required
                                    && q_empty;
    // without txr the head is only peeked, and an empty queue is quiet
    wire [DATA_W-1:0]    load_byte = q_empty ? recv_byte : head_data;

    always_comb begin
        link_next = link_reg;
        unique case (link_reg)
            SSTP_LINK_IDLE:   if (sel_now) link_next = SSTP_LINK_ACTIVE;
            SSTP_LINK_ACTIVE: if (!sel_now) link_next = SSTP_LINK_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            link_reg     <= SSTP_LINK_IDLE;
            bit_cnt_reg  <= '0;
            tx_byte_reg  <= TXB_RESET;
            rx_shift_reg <= TXB_RESET;
            last_rx_reg  <= TXB_RESET;
        end else begin
            link_reg <= link_next;
            if (!sel_now) bit_cnt_reg <= '0;
            else if (sck_fall && link_reg == SSTP_LINK_ACTIVE) bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (sel_now && sck_rise) rx_shift_reg <= {rx_shift_reg[DATA_W-2:0], sdi_sync_reg[2]};
            if (byte_end) last_rx_reg <= rx_shift_reg;
            if (load) tx_byte_reg <= load_byte;
        end
    end

    // pin drive
    wire tx_bit = tx_byte_reg[LAST_BIT - bit_cnt_reg];
    assign SDO_OE = ctrl_reg.pin_tristate_control
                  ? (ctrl_reg.transmit_data_required && sel_f_reg)
                  : 1'b1;
    assign SDO_O  = sel_f_reg ? tx_bit : ctrl_reg.pin_output_latch;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
        end
    end

    // interrupt flags: set beats a read clear, and only bits the read returned are cleared
    // so an event landing in the sample cycle is not lost
    wire [31:0] status_word = {25'h0, count_reg, 1'b0, wr_err_st_reg, q_full, q_empty};
    wire [$bits(sstp_flags_t)-1:0] flags_seen = rdata_reg[$bits(sstp_flags_t)-1:0];
    always_comb begin
        flags_next = (rd_ok && hit_flags) ? sstp_flags_t'(flags_reg & ~flags_seen) : flags_reg;
        if (underflow_ev) flags_next.tx_underflow_flag = 1'b1;
        if (push_err) flags_next.tx_write_error_flag = 1'b1;
    end

    wire [31:0] rd_mux = hit_clk   ? {28'h0, clksel_reg}
                       : hit_ctrl  ? {29'h0, ctrl_reg}
                       : hit_stat  ? status_word
                       : hit_flags ? {30'h0, flags_reg}
                       : hit_mask  ? {30'h0, mask_reg}
                       : RD_ZERO;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_reg      <= CTRL_RESET;
            clksel_reg    <= CLKSEL_RESET;
            flags_reg     <= FLAGS_RESET;
            mask_reg      <= FLAGS_RESET;
            wr_err_st_reg <= 1'b0;
            ack_reg       <= 1'b0;
            rdata_reg     <= RD_ZERO;
        end else begin
            ack_reg   <= acc && !ack_reg;
            flags_reg <= flags_next;
            if (AVS_READ && !ack_reg) rdata_reg <= rd_mux;
            if (wr_ok && hit_clk) clksel_reg <= AVS_WRITEDATA[SEL_W-1:0];
            if (wr_ok && hit_ctrl) ctrl_reg <= AVS_WRITEDATA[2:0];
            if (wr_ok && hit_mask) mask_reg <= AVS_WRITEDATA[1:0];
            // status error is write-one-to-clear, new error wins
            if (push_err) wr_err_st_reg <= 1'b1;
            else if (wr_ok && hit_stat && AVS_WRITEDATA[ST_WR_ERR]) wr_err_st_reg <= 1'b0;
        end
    end

    assign CLK_SEL = clksel_reg;
    assign IRQ     = |(flags_reg & mask_reg);

    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_wr_accept(logic [4:0] off);
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == off;
    endsequence
    sequence s_rd_accept(logic [4:0] off);
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == off;
    endsequence

    a_drive_tris_clear: assert property (
        !ctrl_reg.pin_tristate_control |-> SDO_OE)
        else $error("pin not driven with tristate clear");
    a_idle_latch_out: assert property (
        !sel_f_reg && !ctrl_reg.pin_tristate_control |-> SDO_O == ctrl_reg.pin_output_latch)
        else $error("idle pin does not follow latch");
    a_oe_tris_set: assert property (
        ctrl_reg.pin_tristate_control |->
        SDO_OE == (ctrl_reg.transmit_data_required && sel_f_reg))
        else $error("tristate drive condition wrong");
    a_pop_on_load: assert property (
        load && ctrl_reg.transmit_data_required && !q_empty && !push
        |=> count_reg == $past(count_reg) - 1'b1 && tx_byte_reg == $past(head_data))
        else $error("queued byte not sent and popped");
    a_underflow_set: assert property (
        load && ctrl_reg.transmit_data_required && q_empty
        |=> flags_reg.tx_underflow_flag && tx_byte_reg == $past(recv_byte))
        else $error("underflow not flagged");
    a_peek_no_pop: assert property (
        load && !ctrl_reg.transmit_data_required && !push && !q_empty
        |=> $stable(count_reg) && tx_byte_reg == $past(head_data))
        else $error("peek changed occupancy");
    a_quiet_empty: assert property (
        load && !ctrl_reg.transmit_data_required && q_empty && !flags_reg.tx_underflow_flag
        |=> !flags_reg.tx_underflow_flag)
        else $error("underflow set without txr");
    a_tris_no_data: assert property (
        ctrl_reg.pin_tristate_control && !ctrl_reg.transmit_data_required |-> !SDO_OE)
        else $error("pin driven with txr clear");
    a_push_append: assert property (
        s_wr_accept(OFF_TX_BUFFER) and (!q_full && !pop)
        |=> count_reg == $past(count_reg) + 1'b1 ##1 1'b1)
        else $error("write not appended");
    a_full_write_err: assert property (
        s_wr_accept(OFF_TX_BUFFER) and q_full
        |=> flags_reg.tx_write_error_flag && wr_err_st_reg && $stable(wr_ptr_reg))
        else $error("full write not flagged");
    a_txb_reads_zero: assert property (
        s_rd_accept(OFF_TX_BUFFER) |-> AVS_READDATA == RD_ZERO)
        else $error("transmit buffer readable");
    a_clksel_write: assert property (
        s_wr_accept(OFF_CLK_SELECT)
        |=> CLK_SEL == $past(AVS_WRITEDATA[SEL_W-1:0]))
        else $error("clock select not stored");
    a_clksel_upper: assert property (
        s_rd_accept(OFF_CLK_SELECT) |-> AVS_READDATA[31:SEL_W] == '0)
        else $error("clock select upper bits set");

    sequence s_req_first;
        (AVS_READ || AVS_WRITE) && !ack_reg;
    endsequence
    a_one_wait_state: assert property (
        s_req_first |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("waitrequest not exactly one cycle");
    a_count_in_range: assert property (
        count_reg <= Q_FULL_CNT)
        else $error("queue occupancy above depth");
    a_underflow_sticky: assert property (
        flags_reg.tx_underflow_flag && !(rd_ok && hit_flags) |=> flags_reg.tx_underflow_flag)
        else $error("underflow flag lost without read");
    a_write_err_sticky: assert property (
        flags_reg.tx_write_error_flag && !(rd_ok && hit_flags) |=> flags_reg.tx_write_error_flag)
        else $error("write error flag lost without read");
    a_set_beats_clear: assert property (
        underflow_ev |=> flags_reg.tx_underflow_flag)
        else $error("underflow event lost to clear");
    a_byte_held: assert property (
        !load |=> $stable(tx_byte_reg))
        else $error("transmit byte changed between loads");
    a_deselect_clears_count: assert property (
        !sel_now |=> bit_cnt_reg == '0)
        else $error("bit count kept across deselect");
    a_peek_keeps_count: assert property (
        !ctrl_reg.transmit_data_required && !push |=> $stable(count_reg))
        else $error("occupancy changed without txr");
    a_irq_masked_off: assert property (
        mask_reg == '0 |-> !IRQ)
        else $error("interrupt with all sources masked");
    a_tris_sel_drive: assert property (
        ctrl_reg.pin_tristate_control && ctrl_reg.transmit_data_required && sel_f_reg
        |-> SDO_OE && SDO_O == tx_bit)
        else $error("selected pin not driven with txr");
    a_tris_idle_hiz: assert property (
        ctrl_reg.pin_tristate_control && !sel_f_reg |-> !SDO_OE)
        else $error("deselected pin driven with tristate set");
endmodule

// *** sim/sstp_spi_master.sv ***
`timescale 1ns/1ps
module sstp_spi_master #(
    parameter int HALF = 16
) (
    // clock
    input  wire logic clk,
    // link
    output logic      sck,
    output logic      ss_n,
    output logic      sdi,
    input  wire logic sdo_o,
    input  wire logic sdo_oe
);
    // undriven pin reads as z, so a tristated byte never matches
    wire sdo_line = sdo_oe ? sdo_o : 1'bz;

    initial begin
        sck  = 1'b0;
        ss_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // deselect waits half a bit so the last fall is seen first
    task automatic sel(input logic on);
        if (!on) wait_cyc(HALF);
        ss_n <= ~on;
        // released line floats: show the inverse of the last bit
        if (!on) sdi <= ~sdi;
        wait_cyc(HALF);
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi <= tx[i];
            wait_cyc(HALF);
            sck <= 1'b1;
            rx[i] = sdo_line;
            wait_cyc(HALF);
            sck <= 1'b0;
        end
    endtask
endmodule

// *** sim/sstp_slave_tx_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("ERROR %s expected %h seen %h", nm, e, g); failures++; end end
module sstp_slave_tx_tb;
    import sstp_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sck, ss_n, sdi, sdo_o, sdo_oe, irq;
    logic [3:0]  clk_sel;
    logic [31:0] rdat;
    int          failures = 0;
    int          comparisons = 0;

    always #2.5 clock = ~clock;

    sstp_slave_tx sstp_slave_tx_i (
        .CLOCK(clock), .RST_N(rst_n),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest),
        .SCK(sck), .SS_N(ss_n), .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
        .CLK_SEL(clk_sel), .IRQ(irq)
    );

    sstp_spi_master sstp_spi_master_i (
        .clk(clock), .sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe)
    );

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // called just after a rising edge; returns one edge after release
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk_rd(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rdat)
    endtask

    task automatic frame(input string nm, input int n, input logic [7:0] tx [5],
                         input logic [7:0] ex [5]);
        logic [7:0] rx;
        sstp_spi_master_i.sel(1'b1);
        for (int k = 0; k < n; k++) begin
            sstp_spi_master_i.xfer(tx[k], rx);
            `CHK(nm, ex[k], rx)
        end
        sstp_spi_master_i.sel(1'b0);
    endtask

    initial begin
        #200000;
        failures++;
        finish_test();
    end

    initial begin
        avs_address   <= 5'h00;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= 32'h0000_0000;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        // link synchronisers need a few cycles to flush
        repeat (4) @(posedge clock);
        `CHK("oe reset", 1'b1, sdo_oe)
        `CHK("sdo reset", 1'b0, sdo_o)
        chk_rd("clksel reset", OFF_CLK_SELECT, 32'h0);
        chk_rd("txb read", OFF_TX_BUFFER, 32'h0);
        chk_rd("unmapped", 5'h18, 32'h0);
        chk_rd("status reset", OFF_STATUS, 32'h1);
        $display("test reset done");

        for (int i = 0; i < 10; i++) begin
            logic [3:0] v;
            v = (i == 9) ? 4'hf : 4'(i);
            bus(1'b1, OFF_CLK_SELECT, {24'h0, 4'hf, v});
            chk_rd("clksel", OFF_CLK_SELECT, {28'h0, v});
            `CHK("clk_sel pin", v, clk_sel)
        end
        $display("test clock select done");

        bus(1'b1, OFF_INT_MASK, 32'h2);
        for (int i = 0; i < 4; i++)
            bus(1'b1, OFF_TX_BUFFER, 32'ha1 + 32'(i) * 32'h11);
        chk_rd("status full", OFF_STATUS, 32'h42);
        `CHK("irq idle", 1'b0, irq)
        bus(1'b1, OFF_TX_BUFFER, 32'he5);
        chk_rd("status werr", OFF_STATUS, 32'h46);
        `CHK("irq werr", 1'b1, irq)
        chk_rd("flags werr", OFF_INT_FLAGS, 32'h2);
        `CHK("irq clear", 1'b0, irq)
        bus(1'b1, OFF_STATUS, 32'h4);
        chk_rd("status w1c", OFF_STATUS, 32'h42);
        $display("test queue fill done");

        // fifth byte underflows and echoes the fourth received byte
        bus(1'b1, OFF_CONTROL, 32'h1);
        frame("pop", 5, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55},
              '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h44});
        chk_rd("status drained", OFF_STATUS, 32'h1);
        bus(1'b1, OFF_INT_MASK, 32'h1);
        `CHK("irq under", 1'b1, irq)
        chk_rd("flags under", OFF_INT_FLAGS, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        $display("test pop done");

        bus(1'b1, OFF_CONTROL, 32'h0);
        frame("peek empty", 1, '{8'h66, 8'h0, 8'h0, 8'h0, 8'h0},
              '{8'h55, 8'h0, 8'h0, 8'h0, 8'h0});
        chk_rd("flags none", OFF_INT_FLAGS, 32'h0);
        bus(1'b1, OFF_TX_BUFFER, 32'h5a);
        repeat (2) @(posedge clock);
        frame("peek", 2, '{8'h77, 8'h78, 8'h0, 8'h0, 8'h0},
              '{8'h5a, 8'h5a, 8'h0, 8'h0, 8'h0});
        chk_rd("status peek", OFF_STATUS, 32'h10);
        $display("test peek done");

        bus(1'b1, OFF_CONTROL, 32'h2);
        sstp_spi_master_i.sel(1'b1);
        `CHK("oe tris sel", 1'b0, sdo_oe)
        sstp_spi_master_i.sel(1'b0);
        `CHK("oe tris desel", 1'b0, sdo_oe)
        bus(1'b1, OFF_CONTROL, 32'h3);
        `CHK("oe txr desel", 1'b0, sdo_oe)
        sstp_spi_master_i.sel(1'b1);
        `CHK("oe txr sel", 1'b1, sdo_oe)
        sstp_spi_master_i.sel(1'b0);
        bus(1'b1, OFF_CONTROL, 32'h4);
        `CHK("oe latch", 1'b1, sdo_oe)
        `CHK("sdo latch", 1'b1, sdo_o)
        $display("test tristate done");
        finish_test();
    end
endmodule
